// ---- src/pllcd_pkg.sv ----
// pllcd_pkg: register map, field layout and reset values of the clock divider config block
// assumes: used by pllcd_top and by the bench (pllcd_host, tb top), which share these names
package pllcd_pkg;

    // -------------------------------------------------------------------------
    // register indices; byte address is four times the index
    // -------------------------------------------------------------------------
    localparam logic [7:0] IDX_MULT_HIGH = 8'h36;
    localparam logic [7:0] IDX_MULT_LOW  = 8'h38;
    localparam logic [7:0] IDX_N_PDM     = 8'h39;
    localparam logic [7:0] IDX_M_DIV     = 8'h3a;
    localparam logic [7:0] IDX_MOD_BCLK  = 8'h3b;
    localparam logic [7:0] IDX_PRI_LOW   = 8'h3c;
    localparam logic [7:0] IDX_SEC_LOW   = 8'h3d;
    localparam logic [7:0] IDX_AUTO_CTRL = 8'h3f;
    localparam logic [7:0] IDX_STATUS0   = 8'h40;
    localparam logic [7:0] IDX_STATUS1   = 8'h41;

    // -------------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------------
    localparam logic [7:0] RST_MULT_HIGH = 8'h00;
    localparam logic [7:0] RST_MULT_LOW  = 8'h08;
    localparam logic [7:0] RST_N_PDM     = 8'h20;
    localparam logic [7:0] RST_M_DIV     = 8'h04;
    localparam logic [7:0] RST_MOD_BCLK  = 8'h00;
    localparam logic [7:0] RST_PRI_LOW   = 8'h01;
    localparam logic [7:0] RST_SEC_LOW   = 8'h01;
    localparam logic [7:0] RST_AUTO_CTRL = 8'h00;

    // -------------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------------
    localparam int MULT_HIGH_BIT = 7;
    localparam int N_DIV_LSB     = 5;
    localparam int DENSITY_MOD_CLOCK_DIVIDER_LSB   = 2;
    localparam int M_DIV_LSB     = 2;
    localparam int MOD_DIV_LSB   = 4;
    localparam int PRI_HIGH_BIT  = 2;
    localparam int SEC_HIGH_BIT  = 1;
    localparam int AUTO_EN_BIT   = 0;

    // writable bits of each partly reserved register; others are reserved and hold reset value
    localparam logic [7:0] WMASK_MULT_HIGH = 8'h80;
    localparam logic [7:0] WMASK_N_PDM     = 8'hfc;
    localparam logic [7:0] WMASK_M_DIV     = 8'hfc;
    localparam logic [7:0] WMASK_MOD_BCLK  = 8'h36;
    localparam logic [7:0] WMASK_AUTO_CTRL = 8'h01;

    // ratios used while automatic detection owns the clock tree
    localparam logic [8:0] AUTO_MULT  = 9'h008;
    localparam logic [9:0] AUTO_RATIO = 10'h001;

endpackage

// ---- src/pllcd_top.sv ----
// pllcd_top: APB slave holding the PLL multiplier and clock divider configuration,
// decoding it into effective ratios for the clock tree.
// assumes: APB3 master on pclk; byte address is four times the register index.
// How it works
// - multiplier is high bit joined with low byte
// - codes 1..511 select that multiplier, zero reserved
// - multiplier low byte resets to eight
// - auto detection overrides every ratio field
// - N divider code 0 means 8
// - PDM codes 0..4 give 1,2,4,8,16
// - M divider code 0 means 64, resets 1
// - modulator codes 0..2 give 1,2,4
// - bit 2 is primary bitclk divider high
// - bit 1 is secondary bitclk divider high
// - bitclk divider code 0 means 512
// - multiplier high bit is bit 7, resets 0
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps

module pllcd_top (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // effective ratios to the clock tree
    output logic [8:0]       pll_mult,
    output logic [3:0]       n_ratio,
    output logic [4:0]       pdm_ratio,
    output logic [6:0]       m_ratio,
    output logic [2:0]       mod_ratio,
    output logic [9:0]       pri_ratio,
    output logic [9:0]       sec_ratio,
    output logic             auto_active
);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  mult_high;
        logic [7:0]  mult_low;
        logic [7:0]  n_pdm;
        logic [7:0]  m_div;
        logic [7:0]  mod_bclk;
        logic [7:0]  pri_low;
        logic [7:0]  sec_low;
        logic [7:0]  auto_ctrl;
        logic        ready;
        logic [31:0] rdata;
        logic        slverr;
        logic [8:0]  mult;
        logic [3:0]  n;
        logic [4:0]  pdm;
        logic [6:0]  m;
        logic [2:0]  modr;
        logic [9:0]  pri;
        logic [9:0]  sec;
        logic        auto_en;
    } pllcd_state_t;

    pllcd_state_t st_q;
    pllcd_state_t st_d;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    function automatic logic [7:0] masked_wr(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] mask);
        masked_wr = (old_v & ~mask) | (new_v & mask);
    endfunction

    // power-of-two ratio; reserved codes fall back to the largest legal one
    function automatic logic [4:0] pow2_ratio(input logic [2:0] code, input logic [2:0] max_code);
        logic [2:0] c;
        c = (code > max_code) ? max_code : code;
        pow2_ratio = 5'h01 << c;
    endfunction

    logic       access;
    logic [7:0] idx;
    logic       idx_ok;
    logic [7:0] rd_byte;
    logic [8:0] pri_code;
    logic [8:0] sec_code;
    logic [5:0] m_code;
    logic [2:0] n_code;
    logic [4:0] pdm_r;
    logic [4:0] mod_r;

    assign access = psel && penable && !st_q.ready;

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        idx         = paddr[9:2];
        idx_ok      = 1'b1;
        rd_byte     = 8'h00;
        st_d.ready  = access;
        st_d.slverr = 1'b0;
        if (!access)
            st_d.rdata = 32'h0000_0000;

        case (idx)
            pllcd_pkg::IDX_MULT_HIGH: rd_byte = st_q.mult_high;
            pllcd_pkg::IDX_MULT_LOW:  rd_byte = st_q.mult_low;
            pllcd_pkg::IDX_N_PDM:     rd_byte = st_q.n_pdm;
            pllcd_pkg::IDX_M_DIV:     rd_byte = st_q.m_div;
            pllcd_pkg::IDX_MOD_BCLK:  rd_byte = st_q.mod_bclk;
            pllcd_pkg::IDX_PRI_LOW:   rd_byte = st_q.pri_low;
            pllcd_pkg::IDX_SEC_LOW:   rd_byte = st_q.sec_low;
            pllcd_pkg::IDX_AUTO_CTRL: rd_byte = st_q.auto_ctrl;
            pllcd_pkg::IDX_STATUS0:   rd_byte = st_q.mult[7:0];
            pllcd_pkg::IDX_STATUS1:   rd_byte = {st_q.auto_en, 6'h00, st_q.mult[8]};
            default:                  idx_ok  = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00)
            idx_ok = 1'b0;

        if (access) begin
            st_d.slverr = !idx_ok;
            if (!pwrite && idx_ok)
                st_d.rdata = {24'h00_0000, rd_byte};
            if (pwrite && idx_ok) begin
                // reserved bits are never stored, so they keep reset value
                case (idx)
                    pllcd_pkg::IDX_MULT_HIGH: st_d.mult_high = masked_wr(st_q.mult_high, pwdata[7:0],
                                                                         pllcd_pkg::WMASK_MULT_HIGH);
                    pllcd_pkg::IDX_MULT_LOW:  st_d.mult_low  = pwdata[7:0];
                    pllcd_pkg::IDX_N_PDM:     st_d.n_pdm     = masked_wr(st_q.n_pdm, pwdata[7:0],
                                                                         pllcd_pkg::WMASK_N_PDM);
                    pllcd_pkg::IDX_M_DIV:     st_d.m_div     = masked_wr(st_q.m_div, pwdata[7:0],
                                                                         pllcd_pkg::WMASK_M_DIV);
                    pllcd_pkg::IDX_MOD_BCLK:  st_d.mod_bclk  = masked_wr(st_q.mod_bclk, pwdata[7:0],
                                                                         pllcd_pkg::WMASK_MOD_BCLK);
                    pllcd_pkg::IDX_PRI_LOW:   st_d.pri_low   = pwdata[7:0];
                    pllcd_pkg::IDX_SEC_LOW:   st_d.sec_low   = pwdata[7:0];
                    pllcd_pkg::IDX_AUTO_CTRL: st_d.auto_ctrl = masked_wr(st_q.auto_ctrl, pwdata[7:0],
                                                                         pllcd_pkg::WMASK_AUTO_CTRL);
                    default: ;
                endcase
            end
        end

        // decode from current fields; outputs lag a write by one cycle
        pri_code = {st_q.mod_bclk[pllcd_pkg::PRI_HIGH_BIT], st_q.pri_low};
        sec_code = {st_q.mod_bclk[pllcd_pkg::SEC_HIGH_BIT], st_q.sec_low};
        m_code   = st_q.m_div[pllcd_pkg::M_DIV_LSB +: 6];
        n_code   = st_q.n_pdm[pllcd_pkg::N_DIV_LSB +: 3];
        pdm_r    = pow2_ratio(st_q.n_pdm[pllcd_pkg::DENSITY_MOD_CLOCK_DIVIDER_LSB +: 3], 3'd4);
        mod_r    = pow2_ratio({1'b0, st_q.mod_bclk[pllcd_pkg::MOD_DIV_LSB +: 2]}, 3'd2);
        st_d.auto_en = st_q.auto_ctrl[pllcd_pkg::AUTO_EN_BIT];

        if (st_q.auto_ctrl[pllcd_pkg::AUTO_EN_BIT]) begin
            // auto detection owns the tree; programmed fields are ignored
            st_d.mult = pllcd_pkg::AUTO_MULT;
            st_d.n    = 4'h1;
            st_d.pdm  = 5'h01;
            st_d.m    = 7'h01;
            st_d.modr = 3'h1;
            st_d.pri  = pllcd_pkg::AUTO_RATIO;
            st_d.sec  = pllcd_pkg::AUTO_RATIO;
        end else begin
            // code zero is reserved; passed through as-is
            st_d.mult = {st_q.mult_high[pllcd_pkg::MULT_HIGH_BIT], st_q.mult_low};
            st_d.n    = (n_code == 3'h0) ? 4'h8 : {1'b0, n_code};
            st_d.pdm  = pdm_r;
            st_d.m    = (m_code == 6'h00) ? 7'h40 : {1'b0, m_code};
            st_d.modr = mod_r[2:0];
            st_d.pri  = (pri_code == 9'h000) ? 10'h200 : {1'b0, pri_code};
            st_d.sec  = (sec_code == 9'h000) ? 10'h200 : {1'b0, sec_code};
        end
    end

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.mult_high <= pllcd_pkg::RST_MULT_HIGH;
            st_q.mult_low  <= pllcd_pkg::RST_MULT_LOW;
            st_q.n_pdm     <= pllcd_pkg::RST_N_PDM;
            st_q.m_div     <= pllcd_pkg::RST_M_DIV;
            st_q.mod_bclk  <= pllcd_pkg::RST_MOD_BCLK;
            st_q.pri_low   <= pllcd_pkg::RST_PRI_LOW;
            st_q.sec_low   <= pllcd_pkg::RST_SEC_LOW;
            st_q.auto_ctrl <= pllcd_pkg::RST_AUTO_CTRL;
            st_q.ready     <= 1'b0;
            st_q.rdata     <= 32'h0000_0000;
            st_q.slverr    <= 1'b0;
            st_q.mult      <= 9'h008;
            st_q.n         <= 4'h1;
            st_q.pdm       <= 5'h01;
            st_q.m         <= 7'h01;
            st_q.modr      <= 3'h1;
            st_q.pri       <= 10'h001;
            st_q.sec       <= 10'h001;
            st_q.auto_en   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pready      = st_q.ready;
    assign prdata      = st_q.rdata;
    assign pslverr     = st_q.slverr;
    assign pll_mult    = st_q.mult;
    assign n_ratio     = st_q.n;
    assign pdm_ratio   = st_q.pdm;
    assign m_ratio     = st_q.m;
    assign mod_ratio   = st_q.modr;
    assign pri_ratio   = st_q.pri;
    assign sec_ratio   = st_q.sec;
    assign auto_active = st_q.auto_en;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    mult_concat_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_q.auto_ctrl[0] |=> pll_mult == {$past(st_q.mult_high[7]), $past(st_q.mult_low)})
        else $error("multiplier not high bit joined with low byte");

    auto_override_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.auto_ctrl[0] |=> pll_mult == pllcd_pkg::AUTO_MULT && m_ratio == 7'h01 && pri_ratio == 10'h001)
        else $error("ratios not overridden under auto detection");

    n_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.n_pdm[7:5] == 3'h0) |=> n_ratio == 4'h8)
        else $error("n code zero not eight");

    pdm_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.n_pdm[4:2] <= 3'h4) |=> pdm_ratio == (5'h01 << $past(st_q.n_pdm[4:2])))
        else $error("pdm ratio wrong");

    m_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.m_div[7:2] == 6'h00) |=> m_ratio == 7'h40)
        else $error("m code zero not sixty-four");

    mod_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.mod_bclk[5:4] == 2'h2) |=> mod_ratio == 3'h4)
        else $error("modulator ratio wrong");

    pri_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.mod_bclk[2] && st_q.pri_low != 8'h00)
        |=> pri_ratio == {2'b01, $past(st_q.pri_low)})
        else $error("primary high bit not used");

    sec_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && !st_q.mod_bclk[1] && st_q.sec_low == 8'h00) |=> sec_ratio == 10'h200)
        else $error("secondary code zero not 512");

    read_back_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && !pready && paddr == 12'h0e0)
        |=> prdata == {24'h00_0000, $past(st_q.mult_low)})
        else $error("low byte read back differs");

    write_land_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && !pready && paddr == 12'h0e0) |=> st_q.mult_low == $past(pwdata[7:0]))
        else $error("low byte write not stored");

    pri_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && !st_q.mod_bclk[2] && st_q.pri_low == 8'h00) |=> pri_ratio == 10'h200)
        else $error("primary code zero not 512");

    sec_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.mod_bclk[1] && st_q.sec_low != 8'h00)
        |=> sec_ratio == {2'b01, $past(st_q.sec_low)})
        else $error("secondary high bit not used");

    n_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.n_pdm[7:5] != 3'h0) |=> n_ratio == {1'b0, $past(st_q.n_pdm[7:5])})
        else $error("n ratio not its code");

    m_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.m_div[7:2] != 6'h00) |=> m_ratio == {1'b0, $past(st_q.m_div[7:2])})
        else $error("m ratio not its code");

    mod_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_q.auto_ctrl[0] && st_q.mod_bclk[5:4] == 2'h1) |=> mod_ratio == 3'h2)
        else $error("modulator code one not two");

    high_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q.mult_high[6:0] == 7'h00)
        else $error("multiplier high reserved bits not zero");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("slave error without ready");

    rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside answer");

endmodule

// ---- dv/pllcd_host.sv ----
// pllcd_host: apb host model that writes and reads the clock divider config block
// assumes: one pclk domain; the bench calls xfer only after reset is released
`timescale 1ns/1ps
module pllcd_host (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    // apb answer
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    // ---------------------------------------------------------------
    // reserved bits only ever carry their reset value of zero
    // ---------------------------------------------------------------
    function automatic logic [7:0] legal(input logic [7:0] idx, input logic [7:0] d);
        case (idx)
            pllcd_pkg::IDX_MULT_HIGH: return d & pllcd_pkg::WMASK_MULT_HIGH;
            pllcd_pkg::IDX_N_PDM:     return d & pllcd_pkg::WMASK_N_PDM;
            pllcd_pkg::IDX_M_DIV:     return d & pllcd_pkg::WMASK_M_DIV;
            pllcd_pkg::IDX_MOD_BCLK:  return d & pllcd_pkg::WMASK_MOD_BCLK;
            pllcd_pkg::IDX_AUTO_CTRL: return d & pllcd_pkg::WMASK_AUTO_CTRL;
            default:                  return d;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // one transfer; request held until pready is seen at a rising edge
    // ---------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= {24'h000000, legal(addr[9:2], d)};
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle limit here: only the bench watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ---- dv/pll_and_clock_divider_config_tb_top.sv ----
// bench top: random and corner writes, read-back and decoded ratio checks
// assumes: pllcd_host drives apb; reserved bits written as zero
`timescale 1ns/1ps
module pll_and_clock_divider_config_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, auto_active, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r, r2;
    logic [8:0]  pll_mult;
    logic [3:0]  n_ratio;
    logic [4:0]  pdm_ratio;
    logic [6:0]  m_ratio;
    logic [2:0]  mod_ratio;
    logic [9:0]  pri_ratio, sec_ratio;
    logic [7:0]  mh, ml, np, md, mb, pl, sl, ac;
    int          n_errors, checked;

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    pllcd_top pllcd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pll_mult(pll_mult), .n_ratio(n_ratio), .pdm_ratio(pdm_ratio),
        .m_ratio(m_ratio), .mod_ratio(mod_ratio), .pri_ratio(pri_ratio), .sec_ratio(sec_ratio),
        .auto_active(auto_active));
    pllcd_host pllcd_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    // ---------------------------------------------------------------
    // compares and bus helpers
    // ---------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_ratio(input logic [9:0] got, input logic [9:0] exp, input string what);
        chk_word({22'h000000, got}, {22'h000000, exp}, what);
    endtask
    function automatic logic [9:0] div512(input logic [8:0] c);
        return (c == 9'h000) ? 10'h200 : {1'b0, c};
    endfunction
    task automatic model_reset();
        mh = pllcd_pkg::RST_MULT_HIGH;
        ml = pllcd_pkg::RST_MULT_LOW;
        np = pllcd_pkg::RST_N_PDM;
        md = pllcd_pkg::RST_M_DIV;
        mb = pllcd_pkg::RST_MOD_BCLK;
        pl = pllcd_pkg::RST_PRI_LOW;
        sl = pllcd_pkg::RST_SEC_LOW;
        ac = pllcd_pkg::RST_AUTO_CTRL;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        pllcd_host_i.xfer(1'b1, {2'b00, idx, 2'b00}, d, rd, err);
        case (idx)
            pllcd_pkg::IDX_MULT_HIGH: mh = d;
            pllcd_pkg::IDX_MULT_LOW:  ml = d;
            pllcd_pkg::IDX_N_PDM:     np = d;
            pllcd_pkg::IDX_M_DIV:     md = d;
            pllcd_pkg::IDX_MOD_BCLK:  mb = d;
            pllcd_pkg::IDX_PRI_LOW:   pl = d;
            pllcd_pkg::IDX_SEC_LOW:   sl = d;
            default:                  ac = d;
        endcase
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input logic eerr);
        pllcd_host_i.xfer(1'b0, a, 8'h00, rd, err);
        chk_word(rd, {24'h000000, exp}, "read data");
        chk_word({31'h0, err}, {31'h0, eerr}, "slave error");
    endtask
    task automatic rd_all();
        logic [8:0] em;
        em = ac[0] ? 9'h008 : {mh[7], ml};
        rdchk({2'b00, pllcd_pkg::IDX_MULT_HIGH, 2'b00}, mh, 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_MULT_LOW, 2'b00}, ml, 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_N_PDM, 2'b00}, np, 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_M_DIV, 2'b00}, md, 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_MOD_BCLK, 2'b00}, mb, 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_PRI_LOW, 2'b00}, pl, 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_SEC_LOW, 2'b00}, sl, 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_AUTO_CTRL, 2'b00}, ac, 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_STATUS0, 2'b00}, em[7:0], 1'b0);
        rdchk({2'b00, pllcd_pkg::IDX_STATUS1, 2'b00}, {ac[0], 6'h00, em[8]}, 1'b0);
    endtask
    // outputs lag the register by one cycle, so look one edge later
    task automatic chk_outs();
        logic a;
        a = ac[0];
        @(posedge pclk);
        #1;
        chk_ratio({1'b0, pll_mult}, a ? 10'h008 : {1'b0, mh[7], ml}, "mult");
        chk_ratio({6'h00, n_ratio}, a ? 10'h001 : (np[7:5] == 3'h0 ? 10'h008 : {7'h00, np[7:5]}), "n");
        chk_ratio({5'h00, pdm_ratio}, a ? 10'h001 : 10'h001 << np[4:2], "pdm");
        chk_ratio({3'h0, m_ratio}, a ? 10'h001 : (md[7:2] == 6'h00 ? 10'h040 : {4'h0, md[7:2]}), "m");
        chk_ratio({7'h00, mod_ratio}, a ? 10'h001 : 10'h001 << mb[5:4], "mod");
        chk_ratio(pri_ratio, a ? 10'h001 : div512({mb[2], pl}), "pri");
        chk_ratio(sec_ratio, a ? 10'h001 : div512({mb[1], sl}), "sec");
        chk_ratio({9'h000, auto_active}, {9'h000, a}, "auto");
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        #3000000;
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        final_report();
    end
    initial begin
        presetn = 1'b0;
        n_errors = 0;
        checked = 0;
        model_reset();
        void'($urandom(44620));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk_outs();
        rd_all();
        $display("test reset values done");
        // first pass is all-zero codes except multiplier code 256, second all-maximum codes
        for (int i = 0; i < 24; i++) begin
            r  = (i == 0) ? 32'h00000000 : (i == 1) ? 32'hffffffff : $urandom;
            r2 = (i == 0) ? 32'h00000000 : (i == 1) ? 32'hffffffff : $urandom;
            if ({r[0], r[8:1]} == 9'h000) r[0] = 1'b1;
            if (r[11:9] > 3'h4) r[11:9] = 3'h4;
            if (r[13:12] == 2'h3) r[13:12] = 2'h2;
            wr(pllcd_pkg::IDX_MULT_HIGH, {r[0], 7'h00});
            wr(pllcd_pkg::IDX_MULT_LOW, r[8:1]);
            wr(pllcd_pkg::IDX_N_PDM, {r[16:14], r[11:9], 2'b00});
            wr(pllcd_pkg::IDX_M_DIV, {r[22:17], 2'b00});
            wr(pllcd_pkg::IDX_MOD_BCLK, {2'b00, r[13:12], 1'b0, r[23], r[24], 1'b0});
            wr(pllcd_pkg::IDX_PRI_LOW, r2[7:0]);
            wr(pllcd_pkg::IDX_SEC_LOW, r2[15:8]);
            chk_outs();
            rd_all();
        end
        $display("test random ratios done");
        wr(pllcd_pkg::IDX_AUTO_CTRL, 8'h01);
        chk_outs();
        wr(pllcd_pkg::IDX_N_PDM, 8'he8);
        chk_outs();
        rd_all();
        wr(pllcd_pkg::IDX_AUTO_CTRL, 8'h00);
        chk_outs();
        $display("test auto detection done");
        rdchk({2'b00, 8'h37, 2'b00}, 8'h00, 1'b1);
        pllcd_host_i.xfer(1'b1, {2'b00, pllcd_pkg::IDX_N_PDM, 2'b01}, 8'h40, rd, err);
        chk_word({31'h0, err}, 32'h00000001, "misaligned write");
        pllcd_host_i.xfer(1'b1, {2'b01, pllcd_pkg::IDX_M_DIV, 2'b00}, 8'h08, rd, err);
        chk_word({31'h0, err}, 32'h00000001, "high address write");
        pllcd_host_i.xfer(1'b1, {2'b00, pllcd_pkg::IDX_STATUS0, 2'b00}, 8'hff, rd, err);
        chk_word({31'h0, err}, 32'h00000000, "status write");
        rd_all();
        chk_outs();
        $display("test refused accesses done");
        // reset again mid-run: every field must drop back to its reset value
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        model_reset();
        chk_outs();
        rd_all();
        $display("test mid-run reset done");
        final_report();
    end
endmodule
